/* hw/can_tx_dominant_timeout.v */
// Purpose: transmit-path guard of an isolated CAN transceiver
// Assumes: free-running 250 MHz timebase, pin inputs asynchronous
// Notes: bus driver modelled as enable plus dominant request
// Operation
// - A low transmit input held longer than 2 ms disables the driver, releasing the bus.
// - After the timeout the driver stays off until a rising edge on the transmit input or until undervoltage clears.
// - The path carries traffic at bit rates up to 1 Mbps with little added delay.
// - A current-limit event from a bus short never latches; transmission resumes alone.
// - The bus is driven dominant for a low input without timeout, over temperature or current limit, else held recessive outside undervoltage.
// - Over temperature disables the driver, biases recessive, and keeps receive working.
// - Undervoltage puts bus outputs and receive output in high impedance until valid.
`timescale 1ns/100ps
`include "can_txguard_consts.vh"
module can_tx_dominant_timeout #(
    parameter TIMEOUT_CYC = `DOM_TIMEOUT_CYC,
    parameter CNT_W = `DOM_CNT_W
) (
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // controller side pins
    input wire i_tx_data,
    output reg o_rx_data,
    output reg o_rx_data_oe,
    // bus side
    input wire i_bus_dominant,
    output reg o_bus_drive_dominant,
    output reg o_bus_oe,
    output reg o_bus_bias_recessive,
    // protection inputs
    input wire i_over_temp,
    input wire i_under_voltage,
    input wire i_current_limit,
    // status
    output reg o_timeout_fault
);
    // run length that counts as a stuck dominant input
    localparam [CNT_W-1:0] LIMIT = TIMEOUT_CYC[CNT_W-1:0];
    // filtered pin levels
    wire tx_level;
    wire bus_level;
    wire ot_level;
    wire uv_level;
    wire cl_level;
    // edge memory and dominant-run counter
    reg tx_prev;
    reg [CNT_W-1:0] low_cnt;
    // guard state
    reg [1:0] state;
    reg [1:0] next_state;
    // qualified events and drive permission
    wire tx_rise;
    wire run_expired;
    wire next_drive;

    // ======================================================
    // protected-mode decode, shared by the bus driver and receive path
    function in_protect;
        input [1:0] st;
        begin
            in_protect = (st == `ST_PROTECT);
        end
    endfunction

    // ======================================================
    // drive only in normal state, on a low input, with no protection
    function drive_allowed;
        input [1:0] st;
        input tx;
        input ot;
        input cl;
        begin
            drive_allowed = (st == `ST_NORMAL) && !tx && !ot && !cl;
        end
    endfunction

    // ======================================================
    // pin synchronisers
    pin_sync3 #(.RESET_VAL(1'b1)) u_tx (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_tx_data),
        .o_level(tx_level)
    );
    pin_sync3 #(.RESET_VAL(1'b0)) u_bus (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_bus_dominant),
        .o_level(bus_level)
    );
    pin_sync3 #(.RESET_VAL(1'b0)) u_ot (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_over_temp),
        .o_level(ot_level)
    );
    pin_sync3 #(.RESET_VAL(1'b1)) u_uv (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_under_voltage),
        .o_level(uv_level)
    );
    pin_sync3 #(.RESET_VAL(1'b0)) u_cl (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_current_limit),
        .o_level(cl_level)
    );

    // ======================================================
    // dominant-run counter, saturates at the limit
    // saturating keeps a stuck input from wrapping back below the limit
    // and quietly re-arming the driver while the pin is still low
    always @(posedge i_clk) begin
        if (i_rst) begin
            low_cnt <= {CNT_W{1'b0}};
            tx_prev <= 1'b1;
        end else begin
            tx_prev <= tx_level;
            if (tx_level) begin
                low_cnt <= {CNT_W{1'b0}};
            end else if (low_cnt != LIMIT) begin
                low_cnt <= low_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // ======================================================
    // qualified events feeding the state machine
    // rising edge of the filtered input ends a timeout
    assign tx_rise = tx_level && !tx_prev;
    // run reached the limit while the input is still low
    assign run_expired = !tx_level && (low_cnt == LIMIT);
    // drive request for the coming cycle
    assign next_drive = drive_allowed(next_state, tx_level, ot_level, cl_level);

    // ======================================================
    // guard state selection
    always @* begin
        next_state = state;
        case (state)
            `ST_NORMAL: begin
                // undervoltage overrides everything else
                if (uv_level) begin
                    next_state = `ST_PROTECT;
                end else if (run_expired) begin
                    next_state = `ST_TIMEOUT;
                end
            end
            `ST_TIMEOUT: begin
                // a fresh rising edge re-arms the driver; undervoltage re-arms it via protect once it clears
                if (uv_level) begin
                    next_state = `ST_PROTECT;
                end else if (tx_rise) begin
                    next_state = `ST_NORMAL;
                end
            end
            `ST_PROTECT: begin
                // supplies valid again: back to normal
                if (!uv_level) begin
                    next_state = `ST_NORMAL;
                end
            end
            default: begin
                next_state = `ST_PROTECT;
            end
        endcase
    end

    // ======================================================
    // state register
    always @(posedge i_clk) begin
        if (i_rst) begin
            state <= `ST_PROTECT;
        end else begin
            state <= next_state;
        end
    end

    // ======================================================
    // bus driver; current limit and heat gate drive without latching
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_bus_drive_dominant <= 1'b0;
            o_bus_oe <= 1'b0;
            o_bus_bias_recessive <= 1'b0;
        end else if (in_protect(next_state)) begin
            o_bus_drive_dominant <= 1'b0;
            o_bus_oe <= 1'b0;
            o_bus_bias_recessive <= 1'b0; // bus lines float
        end else begin
            o_bus_drive_dominant <= next_drive;
            o_bus_oe <= next_drive;
            o_bus_bias_recessive <= 1'b1;
        end
    end

    // ======================================================
    // receive path mirrors the bus, stays live in heat shutdown
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_rx_data <= 1'b1;
            o_rx_data_oe <= 1'b0;
        end else if (in_protect(next_state)) begin
            o_rx_data <= 1'b1;
            o_rx_data_oe <= 1'b0;
        end else begin
            o_rx_data <= !bus_level;
            o_rx_data_oe <= 1'b1;
        end
    end

    // ======================================================
    // dominant-timeout status flag
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_timeout_fault <= 1'b0;
        end else begin
            o_timeout_fault <= (next_state == `ST_TIMEOUT);
        end
    end
endmodule

/* hw/can_txguard_consts.vh */
// Purpose: constants for the transmit dominant-timeout guard
// Assumes: 250 MHz core clock
// Notes: times in their own units, cycle counts derived
`ifndef CAN_TXGUARD_CONSTS_VH
`define CAN_TXGUARD_CONSTS_VH
// ==========================================================
// timing
`define CLK_FREQ_HZ 250000000
`define DOM_TIMEOUT_US 2000
// cycles of continuous low before the driver is released
`define DOM_TIMEOUT_CYC ((`DOM_TIMEOUT_US * (`CLK_FREQ_HZ / 1000000)))
`define DOM_CNT_W 20
// ==========================================================
// guard states
`define ST_NORMAL 2'h0
`define ST_TIMEOUT 2'h1
`define ST_PROTECT 2'h2
`endif

/* hw/pin_sync3.v */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: one clock, synchronous active-high reset
// Notes: stage one feeds only stage two
`timescale 1ns/100ps
module pin_sync3 #(
    parameter RESET_VAL = 1'b1
) (
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // raw pin
    input wire i_pin,
    // filtered level
    output reg o_level
);
    reg s1;
    reg s2;
    reg s3;
    // ======================================================
    // sync chain; level changes once stages two and three agree
    always @(posedge i_clk) begin
        if (i_rst) begin
            s1 <= RESET_VAL;
            s2 <= RESET_VAL;
            s3 <= RESET_VAL;
            o_level <= RESET_VAL;
        end else begin
            s1 <= i_pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                o_level <= s3;
            end
        end
    end
endmodule

/* verif/can_txguard_checker.sv */
// Purpose: port checks of the transmit guard
// Assumes: bound into the guard top
// Notes: cnt counts clean low cycles of the pin
`timescale 1ns/100ps
module can_txguard_checker #(
    parameter TO = 20
) (
    // clock, reset, inputs
    input wire i_clk,
    input wire i_rst,
    input wire i_tx_data,
    input wire i_over_temp,
    input wire i_under_voltage,
    input wire i_current_limit,
    // outputs watched
    input wire o_bus_drive_dominant,
    input wire o_bus_oe,
    input wire o_bus_bias_recessive,
    input wire o_rx_data_oe,
    input wire o_timeout_fault
);
    reg [7:0] cnt;
    // low run length with no protection active
    always @(posedge i_clk) begin
        if (i_rst || i_tx_data || i_over_temp || i_under_voltage || i_current_limit) begin
            cnt <= 8'h00;
        end else if (cnt != 8'hff) begin
            cnt <= cnt + 8'h01;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_drv; cnt == 8'h0a |-> o_bus_drive_dominant && o_bus_oe; endproperty
    a_drv: assert property (p_drv) else $error("no drive on low");
    property p_to; cnt == TO + 14 |-> o_timeout_fault && !o_bus_oe; endproperty
    a_to: assert property (p_to) else $error("no timeout");
    property p_hold; (!i_tx_data)[*6] ##0 o_timeout_fault |=> o_timeout_fault; endproperty
    a_hold: assert property (p_hold) else $error("fault dropped");
    property p_rec; i_tx_data[*6] |-> !o_bus_drive_dominant; endproperty
    a_rec: assert property (p_rec) else $error("drive on high");
    property p_off; o_timeout_fault |-> !o_bus_oe; endproperty
    a_off: assert property (p_off) else $error("drive in fault");
    property p_cl; (i_current_limit && !i_under_voltage)[*8] |-> !o_bus_oe && o_bus_bias_recessive;
    endproperty
    a_cl: assert property (p_cl) else $error("limit drive");
    property p_ot; (i_over_temp && !i_under_voltage)[*8] |-> !o_bus_oe && o_rx_data_oe;
    endproperty
    a_ot: assert property (p_ot) else $error("hot drive");
    property p_uv; i_under_voltage[*6] |-> !o_bus_bias_recessive && !o_rx_data_oe; endproperty
    a_uv: assert property (p_uv) else $error("uv outputs on");
endmodule

/* verif/ctl_model.sv */
// Purpose: controller model on the transmit pin
// Assumes: bench clock
// Notes: one low run per command
`timescale 1ns/100ps
module ctl_model (
    // command
    input wire i_clk,
    input wire i_go,
    input wire [7:0] i_len,
    // pin
    output reg o_tx = 1'b1
);
    reg [7:0] n = 8'h00;
    // low for i_len cycles, then recessive
    always @(posedge i_clk) begin
        n <= i_go ? i_len : n - {7'h00, n != 8'h00};
        o_tx <= !(i_go || n > 8'h01);
    end
endmodule

/* verif/tb_top.sv */
// Purpose: bench of the transmit guard
// Assumes: short timeout parameter
// Notes: frames of random length
`timescale 1ns/100ps
module tb_top;
    localparam TO = 20;
    reg i_clk = 1'b0;
    reg i_rst = 1'b1;
    reg go = 1'b0;
    reg [7:0] len = 8'h00;
    reg [7:0] r;
    reg i_bus_dominant = 1'b0;
    reg i_over_temp = 1'b0;
    reg i_under_voltage = 1'b0;
    reg i_current_limit = 1'b0;
    wire i_tx_data, o_rx_data, o_rx_data_oe, o_bus_drive_dominant;
    wire o_bus_oe, o_bus_bias_recessive, o_timeout_fault;
    integer err_count = 0;
    integer checks_done = 0;
    integer seed = 32'hab936aa9;
    integer k;
    always #2 i_clk = ~i_clk;
    ctl_model ctl_model_i (.i_clk(i_clk), .i_go(go), .i_len(len), .o_tx(i_tx_data));
    can_tx_dominant_timeout #(.TIMEOUT_CYC(TO)) can_tx_dominant_timeout_i (.*);
    task chk(input [39:0] nm, input seen, input exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("wrong value %0s exp %b seen %b", nm, exp, seen);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // one low run, checked near its end and after release
    task frame(input [7:0] n, input e_drv);
        @(posedge i_clk);
        go <= 1'b1;
        len <= n;
        @(posedge i_clk);
        go <= 1'b0;
        repeat (n - 2) @(posedge i_clk);
        #1;
        chk("drive", o_bus_oe, e_drv);
        chk("fault", o_timeout_fault, n > TO + 6);
        chk("rx", o_rx_data | i_under_voltage, i_under_voltage | !i_bus_dominant);
        chk("bias", o_bus_bias_recessive, !i_under_voltage);
        chk("rxoe", o_rx_data_oe, !i_under_voltage);
        repeat (12) @(posedge i_clk);
        #1;
        chk("clear", o_timeout_fault, 1'b0);
        $display("frame %0d done", n);
    endtask
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (8) @(posedge i_clk);
        for (k = 0; k < 12; k = k + 1) begin
            r = $random(seed);
            i_bus_dominant <= r[7];
            frame(8'h0a + {5'h00, r[2:0]}, 1'b1);
        end
        frame(8'h28, 1'b0);
        frame(8'h0c, 1'b1);
        i_current_limit <= 1'b1;
        frame(8'h0c, 1'b0);
        i_current_limit <= 1'b0;
        frame(8'h0c, 1'b1);
        i_over_temp <= 1'b1;
        frame(8'h0c, 1'b0);
        i_over_temp <= 1'b0;
        i_under_voltage <= 1'b1;
        frame(8'h0c, 1'b0);
        i_under_voltage <= 1'b0;
        frame(8'h0c, 1'b1);
        test_done;
    end
    // watchdog
    initial begin
        repeat (3000) @(posedge i_clk);
        err_count = err_count + 1;
        test_done;
    end
endmodule
bind can_tx_dominant_timeout can_txguard_checker #(.TO(TIMEOUT_CYC)) chk_i (.*);
